// *** verilog/fpsc_pkg.sv ***
package fpsc_pkg;
    // Clock and time constants
    localparam int CLK_KHZ = 50000;
    localparam int DEBOUNCE_MS = 10;
    localparam int LONG_PRESS_MS = 800;
    localparam int BLINK_HALF_MS = 250;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
    localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

    // Register byte offsets
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_LAMP = 8'h08;
    localparam logic [7:0] ADDR_LEVEL = 8'h0c;
    localparam logic [7:0] ADDR_PARAM = 8'h40;

    // Config register fields and reset values
    localparam int CFG_CC_BIT = 0;
    localparam int CFG_REF_BIT = 1;
    localparam int CFG_HEAD_BIT = 2;
    localparam int CFG_OVL_LSB = 4;
    localparam logic CFG_CC_RST = 1'h0;
    localparam logic CFG_REF_RST = 1'h0;
    localparam logic CFG_HEAD_RST = 1'h0;

    // Level thresholds in dB below full scale
    localparam logic [7:0] REF_20_DB = 8'h14;
    localparam logic [7:0] REF_18_DB = 8'h12;
    localparam logic [7:0] PEAK_2_DB = 8'h02;
    localparam logic [7:0] PEAK_10_DB = 8'h0a;

    // Parameter cycle
    localparam int NPARAM = 17;
    localparam logic [4:0] P_HUE = 5'h03;
    localparam logic [4:0] P_CC_FIRST = 5'h04;
    localparam logic [4:0] P_CC_LAST = 5'h09;
    localparam logic [4:0] P_CAPTION = 5'h0a;
    localparam logic [4:0] P_HV = 5'h0f;
    localparam logic [4:0] P_GAIN = 5'h10;
    localparam logic [4:0] P_FIRST = 5'h00;
    localparam logic [4:0] P_LAST = 5'h10;

    // Order: bright, contrast, chroma, hue, r/g/b gain, r/g/b offset,
    // caption, meter overlay, timecode, graticule, test, hv shift, gain
    localparam logic [15:0] PARAM_MIN [NPARAM] = '{16'hffe2, 16'h0000, 16'h0000, 16'hff4c,
        16'h0032, 16'h0032, 16'h0032, 16'hffce, 16'hffce, 16'hffce,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hfff4};
    localparam logic [15:0] PARAM_MAX [NPARAM] = '{16'h001e, 16'h0096, 16'h0096, 16'h00b4,
        16'h00b9, 16'h00b9, 16'h00b9, 16'h0032, 16'h0032, 16'h0032,
        16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h000c};
    localparam logic [15:0] PARAM_DEF [NPARAM] = '{16'h0000, 16'h0064, 16'h0064, 16'h0000,
        16'h0064, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Lamp positions
    localparam int L_IN = 0;
    localparam int L_ADJ = 1;
    localparam int L_DISP = 5;
    localparam int L_GAIN = 11;
    localparam int L_LEVEL = 12;
    localparam int L_PWR = 13;
    localparam int NLAMP = 14;

    typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_RED, LAMP_YELLOW} fpsc_lamp_e;
    typedef enum logic [1:0] {OVL_OFF, OVL_STATUS, OVL_CONTROL, OVL_BOTH} fpsc_ovl_e;
    typedef logic [NLAMP-1:0][1:0] fpsc_lamps_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic [3:0] format;
        logic [3:0] frame_rate;
        logic audio_group_first;
        logic audio_group_second;
        logic audio_group_third;
        logic audio_group_fourth;
    } fpsc_in_status_s;

    typedef struct packed {
        logic show_status;
        logic show_control;
        fpsc_in_status_s status;
        logic [4:0] control_id;
        logic [15:0] control_value;
    } fpsc_osd_s;
endpackage

// *** verilog/fpsc_top.sv ***
// Notes on behaviour
// - Input lamp green while input valid
// - Adjust lamps green nominal, red otherwise
// - Overlay lamps green on, dark off
// - Test and shift lamps green when on
// - Gain lamp green nominal, red moved
// - Level lamp green, yellow, red thresholds
// - Reference level selectable -20 or -18
// - Peak threshold selectable -2 or -10
// - Power lamp needs power and regulator
// - Short select press moves forward
// - Long select press moves back
// - Selected parameter lamp blinks
// - Right steps up, left steps down
// - Both arrows restore selected default
// - Overlay selector four settings, both default
// - Status overlay shows format, rate, groups
// - Control overlay shows selected name, value
// - Colour controls join cycle when enabled
// - Colour controls sit after hue
// - Colour inclusion off after reset
module fpsc_top #(
    parameter int DEBOUNCE_CYCLES = fpsc_pkg::DEBOUNCE_CYC,
    parameter int LONG_PRESS_CYCLES = fpsc_pkg::LONG_PRESS_CYC,
    parameter int BLINK_HALF_CYCLES = fpsc_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic key_select_n_in,
    input wire logic key_left_n_in,
    input wire logic key_right_n_in,
    input wire logic power_present_in,
    input wire logic regulator_ok_in,
    input wire fpsc_pkg::fpsc_in_status_s in_status_in,
    input wire logic [7:0] level_db_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output fpsc_pkg::fpsc_lamps_t lamps_out,
    output fpsc_pkg::fpsc_osd_s osd_out,
    output logic [15:0][15:0] param_values_out
);
    if (DEBOUNCE_CYCLES < 1 || LONG_PRESS_CYCLES < 2 || BLINK_HALF_CYCLES < 1) begin : g_bad_timing
        $error("fpsc_top: timing counts out of range");
    end

    localparam int NP = fpsc_pkg::NPARAM;

    typedef struct packed {
        logic [2:0] key_meta;
        logic [2:0] key_sync;
        logic [2:0] key_stable;
        logic [2:0] key_prev;
        logic [2:0][31:0] key_cnt;
        logic [1:0] pwr_meta;
        logic [1:0] pwr_sync;
        logic [31:0] hold_cnt;
        logic long_done;
        logic [31:0] blink_cnt;
        logic blink_on;
        logic [4:0] sel;
        logic [NP-1:0][15:0] param;
        logic colour_correct_in_cycle;
        logic ref_18;
        logic headroom_10;
        logic [1:0] overlay_selector;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        fpsc_pkg::fpsc_lamps_t lamps;
        fpsc_pkg::fpsc_osd_s osd;
    } fpsc_state_s;

    fpsc_state_s st;
    fpsc_state_s next_st;

    function automatic logic is_choice(input logic [4:0] idx);
        is_choice = idx >= fpsc_pkg::P_CAPTION && idx <= fpsc_pkg::P_HV;
    endfunction

    function automatic logic [4:0] sel_next(input logic [4:0] idx, input logic cc);
        logic [4:0] r;
        r = (idx == fpsc_pkg::P_LAST) ? fpsc_pkg::P_FIRST : idx + 5'h01;
        if (!cc && r >= fpsc_pkg::P_CC_FIRST && r <= fpsc_pkg::P_CC_LAST) begin
            r = fpsc_pkg::P_CAPTION;
        end
        sel_next = r;
    endfunction

    function automatic logic [4:0] sel_prev(input logic [4:0] idx, input logic cc);
        logic [4:0] r;
        r = (idx == fpsc_pkg::P_FIRST) ? fpsc_pkg::P_LAST : idx - 5'h01;
        if (!cc && r >= fpsc_pkg::P_CC_FIRST && r <= fpsc_pkg::P_CC_LAST) begin
            r = fpsc_pkg::P_HUE;
        end
        sel_prev = r;
    endfunction

    function automatic logic [15:0] step(input logic [4:0] idx, input logic [15:0] v, input logic up);
        logic [15:0] lo;
        logic [15:0] hi;
        lo = fpsc_pkg::PARAM_MIN[idx];
        hi = fpsc_pkg::PARAM_MAX[idx];
        if (is_choice(idx)) begin
            if (up) begin
                step = ($signed(v) >= $signed(hi)) ? lo : v + 16'h0001;
            end else begin
                step = ($signed(v) <= $signed(lo)) ? hi : v - 16'h0001;
            end
        end else if (up) begin
            step = ($signed(v) >= $signed(hi)) ? hi : v + 16'h0001;
        end else begin
            step = ($signed(v) <= $signed(lo)) ? lo : v - 16'h0001;
        end
    endfunction

    // Lamp owned by a parameter, NLAMP when it has none
    function automatic int lamp_of(input logic [4:0] idx);
        if (idx <= fpsc_pkg::P_HUE) begin
            lamp_of = fpsc_pkg::L_ADJ + int'(idx);
        end else if (idx >= fpsc_pkg::P_CAPTION && idx <= fpsc_pkg::P_HV) begin
            lamp_of = fpsc_pkg::L_DISP + int'(idx - fpsc_pkg::P_CAPTION);
        end else if (idx == fpsc_pkg::P_GAIN) begin
            lamp_of = fpsc_pkg::L_GAIN;
        end else begin
            lamp_of = fpsc_pkg::NLAMP;
        end
    endfunction

    function automatic logic [1:0] nominal_lamp(input logic [15:0] v, input logic [15:0] d);
        nominal_lamp = (v == d) ? fpsc_pkg::LAMP_GREEN : fpsc_pkg::LAMP_RED;
    endfunction

    always_comb begin
        logic [2:0] press;
        logic sel_rel;
        logic [7:0] ref_db;
        logic [7:0] peak_db;
        logic [7:0] waddr;
        logic [7:0] raddr;
        logic [4:0] pidx;
        int sl;
        press = '0;
        sel_rel = 1'b0;
        ref_db = '0;
        peak_db = '0;
        waddr = '0;
        raddr = '0;
        pidx = '0;
        sl = 0;
        next_st = st;

        next_st.key_meta = ~{key_right_n_in, key_left_n_in, key_select_n_in};
        next_st.key_sync = st.key_meta;
        next_st.pwr_meta = {regulator_ok_in, power_present_in};
        next_st.pwr_sync = st.pwr_meta;

        for (int k = 0; k < 3; k++) begin
            if (st.key_sync[k] != st.key_stable[k]) begin
                if (st.key_cnt[k] >= 32'(DEBOUNCE_CYCLES - 1)) begin
                    next_st.key_stable[k] = st.key_sync[k];
                    next_st.key_cnt[k] = '0;
                end else begin
                    next_st.key_cnt[k] = st.key_cnt[k] + 32'h0000_0001;
                end
            end else begin
                next_st.key_cnt[k] = '0;
            end
        end
        next_st.key_prev = st.key_stable;
        press = st.key_stable & ~st.key_prev;
        sel_rel = st.key_prev[0] & ~st.key_stable[0];

        if (st.key_stable[0]) begin
            if (!st.long_done) begin
                if (st.hold_cnt >= 32'(LONG_PRESS_CYCLES - 1)) begin
                    next_st.sel = sel_prev(st.sel, st.colour_correct_in_cycle);
                    next_st.long_done = 1'b1;
                end else begin
                    next_st.hold_cnt = st.hold_cnt + 32'h0000_0001;
                end
            end
        end else begin
            next_st.hold_cnt = '0;
            next_st.long_done = 1'b0;
            if (sel_rel && !st.long_done) begin
                next_st.sel = sel_next(st.sel, st.colour_correct_in_cycle);
            end
        end
        if (!st.colour_correct_in_cycle && st.sel >= fpsc_pkg::P_CC_FIRST && st.sel <= fpsc_pkg::P_CC_LAST) begin
            next_st.sel = fpsc_pkg::P_CAPTION;
        end

        if (st.key_stable[1] && st.key_stable[2] && (press[1] || press[2])) begin
            next_st.param[st.sel] = fpsc_pkg::PARAM_DEF[st.sel];
        end else if (press[2] && !st.key_stable[1]) begin
            next_st.param[st.sel] = step(st.sel, st.param[st.sel], 1'b1);
        end else if (press[1] && !st.key_stable[2]) begin
            next_st.param[st.sel] = step(st.sel, st.param[st.sel], 1'b0);
        end

        if (st.blink_cnt >= 32'(BLINK_HALF_CYCLES - 1)) begin
            next_st.blink_cnt = '0;
            next_st.blink_on = ~st.blink_on;
        end else begin
            next_st.blink_cnt = st.blink_cnt + 32'h0000_0001;
        end

        // Bus write once both halves are held
        next_st.aw_hold = st.aw_hold | (s_axi_awvalid_in & s_axi_awready_out);
        next_st.w_hold = st.w_hold | (s_axi_wvalid_in & s_axi_wready_out);
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_st.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_st.w_data = s_axi_wdata_in;
            next_st.w_strb = s_axi_wstrb_in;
        end
        if (st.bvalid && s_axi_bready_in) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_hold && st.w_hold && !st.bvalid) begin
            waddr = {st.aw_addr[7:2], 2'b00};
            next_st.aw_hold = 1'b0;
            next_st.w_hold = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = fpsc_pkg::RESP_OKAY;
            if (waddr == fpsc_pkg::ADDR_CFG) begin
                if (st.w_strb[0]) begin
                    next_st.colour_correct_in_cycle = st.w_data[fpsc_pkg::CFG_CC_BIT];
                    next_st.ref_18 = st.w_data[fpsc_pkg::CFG_REF_BIT];
                    next_st.headroom_10 = st.w_data[fpsc_pkg::CFG_HEAD_BIT];
                    next_st.overlay_selector = st.w_data[fpsc_pkg::CFG_OVL_LSB +: 2];
                end
            end else if (waddr == fpsc_pkg::ADDR_SEL || waddr == fpsc_pkg::ADDR_LAMP
                         || waddr == fpsc_pkg::ADDR_LEVEL) begin
                next_st.bresp = fpsc_pkg::RESP_OKAY;
            end else if (waddr >= fpsc_pkg::ADDR_PARAM && waddr < fpsc_pkg::ADDR_PARAM + 8'(4 * NP)) begin
                pidx = 5'((waddr - fpsc_pkg::ADDR_PARAM) >> 2);
                if (st.w_strb[0]) begin
                    next_st.param[pidx][7:0] = st.w_data[7:0];
                end
                if (st.w_strb[1]) begin
                    next_st.param[pidx][15:8] = st.w_data[15:8];
                end
            end else begin
                next_st.bresp = fpsc_pkg::RESP_SLVERR;
            end
        end

        if (st.rvalid && s_axi_rready_in) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            raddr = {s_axi_araddr_in[7:2], 2'b00};
            next_st.rvalid = 1'b1;
            next_st.rresp = fpsc_pkg::RESP_OKAY;
            next_st.rdata = '0;
            if (raddr == fpsc_pkg::ADDR_CFG) begin
                next_st.rdata[fpsc_pkg::CFG_CC_BIT] = st.colour_correct_in_cycle;
                next_st.rdata[fpsc_pkg::CFG_REF_BIT] = st.ref_18;
                next_st.rdata[fpsc_pkg::CFG_HEAD_BIT] = st.headroom_10;
                next_st.rdata[fpsc_pkg::CFG_OVL_LSB +: 2] = st.overlay_selector;
            end else if (raddr == fpsc_pkg::ADDR_SEL) begin
                next_st.rdata[4:0] = st.sel;
            end else if (raddr == fpsc_pkg::ADDR_LAMP) begin
                next_st.rdata[2*fpsc_pkg::NLAMP-1:0] = st.lamps;
            end else if (raddr == fpsc_pkg::ADDR_LEVEL) begin
                next_st.rdata[7:0] = level_db_in;
            end else if (raddr >= fpsc_pkg::ADDR_PARAM && raddr < fpsc_pkg::ADDR_PARAM + 8'(4 * NP)) begin
                pidx = 5'((raddr - fpsc_pkg::ADDR_PARAM) >> 2);
                next_st.rdata = {{16{st.param[pidx][15]}}, st.param[pidx]};
            end else begin
                next_st.rresp = fpsc_pkg::RESP_SLVERR;
            end
        end

        next_st.lamps[fpsc_pkg::L_IN] = in_status_in.valid ? fpsc_pkg::LAMP_GREEN : fpsc_pkg::LAMP_OFF;
        for (int i = 0; i < 4; i++) begin
            next_st.lamps[fpsc_pkg::L_ADJ + i] = nominal_lamp(st.param[i], fpsc_pkg::PARAM_DEF[i]);
        end
        for (int i = 0; i < 6; i++) begin
            next_st.lamps[fpsc_pkg::L_DISP + i] = (st.param[int'(fpsc_pkg::P_CAPTION) + i] != '0)
                ? fpsc_pkg::LAMP_GREEN : fpsc_pkg::LAMP_OFF;
        end
        next_st.lamps[fpsc_pkg::L_GAIN] = nominal_lamp(st.param[fpsc_pkg::P_GAIN],
            fpsc_pkg::PARAM_DEF[fpsc_pkg::P_GAIN]);
        ref_db = st.ref_18 ? fpsc_pkg::REF_18_DB : fpsc_pkg::REF_20_DB;
        peak_db = st.headroom_10 ? fpsc_pkg::PEAK_10_DB : fpsc_pkg::PEAK_2_DB;
        if (level_db_in <= peak_db) begin
            next_st.lamps[fpsc_pkg::L_LEVEL] = fpsc_pkg::LAMP_RED;
        end else if (level_db_in >= ref_db) begin
            next_st.lamps[fpsc_pkg::L_LEVEL] = fpsc_pkg::LAMP_GREEN;
        end else begin
            next_st.lamps[fpsc_pkg::L_LEVEL] = fpsc_pkg::LAMP_YELLOW;
        end
        next_st.lamps[fpsc_pkg::L_PWR] = (st.pwr_sync[0] && st.pwr_sync[1])
            ? fpsc_pkg::LAMP_GREEN : fpsc_pkg::LAMP_OFF;
        sl = lamp_of(st.sel);
        if (sl < fpsc_pkg::NLAMP && !st.blink_on) begin
            next_st.lamps[sl] = fpsc_pkg::LAMP_OFF;
        end

        next_st.osd.show_status = st.overlay_selector == fpsc_pkg::OVL_STATUS
            || st.overlay_selector == fpsc_pkg::OVL_BOTH;
        next_st.osd.status = in_status_in;
        next_st.osd.show_control = st.overlay_selector == fpsc_pkg::OVL_CONTROL
            || st.overlay_selector == fpsc_pkg::OVL_BOTH;
        next_st.osd.control_id = st.sel;
        next_st.osd.control_value = st.param[st.sel];
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
            for (int i = 0; i < NP; i++) begin
                st.param[i] <= fpsc_pkg::PARAM_DEF[i];
            end
            st.colour_correct_in_cycle <= fpsc_pkg::CFG_CC_RST;
            st.ref_18 <= fpsc_pkg::CFG_REF_RST;
            st.headroom_10 <= fpsc_pkg::CFG_HEAD_RST;
            st.overlay_selector <= fpsc_pkg::OVL_BOTH;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready_out = !st.aw_hold && !st.bvalid;
    assign s_axi_wready_out = !st.w_hold && !st.bvalid;
    assign s_axi_bvalid_out = st.bvalid;
    assign s_axi_bresp_out = st.bresp;
    // Single outstanding read keeps rdata stable
    assign s_axi_arready_out = !st.rvalid;
    assign s_axi_rvalid_out = st.rvalid;
    assign s_axi_rresp_out = st.rresp;
    assign s_axi_rdata_out = st.rdata;
    assign lamps_out = st.lamps;
    assign osd_out = st.osd;
    assign param_values_out = st.param[15:0];
endmodule

// *** test/fpsc_chk.sv ***
module fpsc_chk (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic power_present_in,
    input wire logic regulator_ok_in,
    input wire fpsc_pkg::fpsc_in_status_s in_status_in,
    input wire logic [7:0] level_db_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire fpsc_pkg::fpsc_lamps_t lamps_out,
    input wire fpsc_pkg::fpsc_osd_s osd_out
);
    // Edges since reset; $past stale until 3
    logic [1:0] up;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_wr;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    a_input_lamp_on: assert property (in_status_in.valid [*5] |-> lamps_out[0] == 2'h1)
        else $error("input lamp not green with valid input");
    a_power_lamp_on: assert property ((power_present_in && regulator_ok_in) [*5] |-> lamps_out[13] == 2'h1)
        else $error("power lamp not green while powered");
    a_power_lamp_off: assert property (!(power_present_in && regulator_ok_in) [*5] |-> lamps_out[13] == 2'h0)
        else $error("power lamp lit without good power");
    a_level_red: assert property (up == 2'h3 && $past(level_db_in) <= 8'h02 |-> lamps_out[12] == 2'h2)
        else $error("level lamp not red at peak");
    a_level_yellow: assert property (up == 2'h3 && $past(level_db_in) inside {[8'h0b:8'h11]} |-> lamps_out[12] == 2'h3)
        else $error("level lamp not yellow between thresholds");
    a_level_green: assert property (up == 2'h3 && $past(level_db_in) >= 8'h14 |-> lamps_out[12] == 2'h1)
        else $error("level lamp not green below reference");
    a_write_answer: assert property (s_wr |=> !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out)
        else $error("write response missing after both channels taken");
    a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped before accepted");
    a_sel_blink: assert property (osd_out.control_id == 5'h0a |-> ##[1:17] lamps_out[5] == 2'h0)
        else $error("selected caption lamp never blinks off");
endmodule

bind fpsc_top fpsc_chk chk_u (.*);

// *** test/fpsc_panel_model.sv ***
module fpsc_panel_model (
    input wire logic clk_in,
    output logic key_select_n_out,
    output logic key_left_n_out,
    output logic key_right_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {key_select_n_out, key_left_n_out, key_right_n_out} = 3'h7;
    // Chosen keys go low together; long idle after lets debounce settle
    task automatic press(input logic [2:0] k, input int hold);
        @(posedge clk_in);
        {key_select_n_out, key_left_n_out, key_right_n_out} <= ~k;
        repeat (hold) @(posedge clk_in);
        {key_select_n_out, key_left_n_out, key_right_n_out} <= 3'h7;
        repeat (24) @(posedge clk_in);
    endtask
endmodule

// *** test/fpsc_tb.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fpsc_note_s;
    logic clk_in = 1'b0, nrst_in = 1'b0, power_present_in = 1'b0, regulator_ok_in = 1'b0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [7:0] level_db_in = 8'h00, s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    fpsc_pkg::fpsc_in_status_s in_status_in = '0;
    wire logic key_select_n_in, key_left_n_in, key_right_n_in;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    fpsc_pkg::fpsc_lamps_t lamps_out;
    fpsc_pkg::fpsc_osd_s osd_out;
    logic [15:0][15:0] param_values_out;
    fpsc_note_s rq[$], bq[$];
    logic [15:0] pv [17];
    logic [4:0] sel = 5'h00;
    logic [5:0] cfg = 6'h30;
    int err_count = 0, checks = 0, cyc = 0, seed = 43144, k;
    always #10 clk_in = ~clk_in;
    fpsc_top #(.DEBOUNCE_CYCLES(4), .LONG_PRESS_CYCLES(20), .BLINK_HALF_CYCLES(8)) dut_u (.*);
    fpsc_panel_model pm_u (.clk_in(clk_in), .key_select_n_out(key_select_n_in), .key_left_n_out(key_left_n_in),
        .key_right_n_out(key_right_n_in));
    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp_note(input string what, input fpsc_note_s n, input logic [31:0] d, input logic [1:0] r);
        checks++;
        if (((d & n.m) !== (n.d & n.m)) || (r !== n.r)) begin
            err_count++;
            $display("unexpected %s: expected %h/%h seen %h/%h", what, n.d & n.m, n.r, d & n.m, r);
        end
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
        if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in) cmp_note("read", rq.pop_front(), s_axi_rdata_out, s_axi_rresp_out);
        if (s_axi_bvalid_out === 1'b1 && s_axi_bready_in) cmp_note("write", bq.pop_front(), 32'h0, s_axi_bresp_out);
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_in);
        bq.push_back('{32'h0, 32'h0, r});
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        do begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_awvalid_in || s_axi_wvalid_in);
        while (!s_axi_bvalid_out) @(posedge clk_in);
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        @(posedge clk_in);
        rq.push_back('{d, m, r});
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do @(posedge clk_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        while (!s_axi_rvalid_out) @(posedge clk_in);
        s_axi_rready_in <= 1'b1;
        @(posedge clk_in);
        s_axi_rready_in <= 1'b0;
    endtask
    task automatic rd_par(input int i);
        axi_rd(fpsc_pkg::ADDR_PARAM + 8'(4 * i), {{16{pv[i][15]}}, pv[i]}, 32'hffff_ffff, 2'h0);
    endtask
    task automatic sel_step(input int hold, input logic [4:0] s);
        pm_u.press(3'h4, hold);
        sel = s;
        cmp_note("control", '{{11'h0, s, pv[s]}, 32'h001f_ffff, 2'h0},
            {11'h0, osd_out.control_id, osd_out.control_value}, 2'h0);
        axi_rd(fpsc_pkg::ADDR_SEL, {27'h0, s}, 32'h0000_001f, 2'h0);
    endtask
    task automatic chk_lamps();
        logic [31:0] e;
        int l;
        e = 32'h0;
        e[1:0] = {1'b0, in_status_in.valid};
        for (int i = 0; i < 4; i++) e[2*i+2 +: 2] = (pv[i] === fpsc_pkg::PARAM_DEF[i]) ? 2'h1 : 2'h2;
        for (int i = 0; i < 6; i++) e[2*i+10 +: 2] = {1'b0, pv[10+i][0]};
        e[23:22] = (pv[16] === 16'h0000) ? 2'h1 : 2'h2;
        e[25:24] = (level_db_in <= (cfg[2] ? 8'h0a : 8'h02)) ? 2'h2 : (level_db_in >= (cfg[1] ? 8'h12 : 8'h14)) ? 2'h1 : 2'h3;
        e[27:26] = {1'b0, power_present_in & regulator_ok_in};
        // Selected lamp blinks, so its bits are not compared
        l = (sel < 4) ? sel + 1 : (sel < 10) ? 14 : (sel < 16) ? sel - 5 : 11;
        axi_rd(fpsc_pkg::ADDR_LAMP, e, ~(32'h0000_0003 << (2 * l)), 2'h0);
    endtask
    initial begin
        foreach (pv[i]) pv[i] = fpsc_pkg::PARAM_DEF[i];
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        axi_rd(fpsc_pkg::ADDR_CFG, 32'h0000_0030, 32'h0000_0037, 2'h0);
        for (int i = 0; i < 17; i++) rd_par(i);
        pm_u.press(3'h1, 10);
        pv[0] = 16'h0001;
        rd_par(0);
        repeat (2) pm_u.press(3'h2, 10);
        pv[0] = 16'hffff;
        rd_par(0);
        pm_u.press(3'h3, 10);
        pv[0] = 16'h0000;
        rd_par(0);
        axi_wr(fpsc_pkg::ADDR_PARAM, 32'h0000_001e, 2'h0);
        pm_u.press(3'h1, 10);
        pv[0] = 16'h001e;
        rd_par(0);
        sel_step(10, 5'h01);
        sel_step(40, 5'h00);
        repeat (3) sel_step(10, sel + 5'h01);
        sel_step(10, 5'h0a);
        sel_step(40, 5'h03);
        cfg[0] = 1'b1;
        axi_wr(fpsc_pkg::ADDR_CFG, {26'h0, cfg}, 2'h0);
        sel_step(10, 5'h04);
        repeat (6) sel_step(10, sel + 5'h01);
        for (int j = 0; j < 4; j++) begin
            cfg[5:4] = 2'(j);
            axi_wr(fpsc_pkg::ADDR_CFG, {26'h0, cfg}, 2'h0);
            repeat (3) @(posedge clk_in);
            cmp_note("overlay", '{32'(j), 32'h0000_0003, 2'h0}, {30'h0, osd_out.show_control, osd_out.show_status}, 2'h0);
        end
        axi_rd(8'h20, 32'h0000_0000, 32'hffff_ffff, fpsc_pkg::RESP_SLVERR);
        axi_wr(8'h90, 32'h0000_0001, fpsc_pkg::RESP_SLVERR);
        repeat (16) begin
            cfg[2:1] = 2'($random(seed));
            axi_wr(fpsc_pkg::ADDR_CFG, {26'h0, cfg}, 2'h0);
            k = 10 + ($unsigned($random(seed)) % 7);
            pv[k] = 16'($unsigned($random(seed)) % 2);
            axi_wr(fpsc_pkg::ADDR_PARAM + 8'(4 * k), {16'h0, pv[k]}, 2'h0);
            pv[1] = 16'h0064 + 16'($unsigned($random(seed)) % 2);
            axi_wr(fpsc_pkg::ADDR_PARAM + 8'h04, {16'h0, pv[1]}, 2'h0);
            level_db_in <= 8'($unsigned($random(seed)) % 32);
            in_status_in <= 13'($random(seed));
            {power_present_in, regulator_ok_in} <= 2'($random(seed));
            repeat (6) @(posedge clk_in);
            cmp_note("status", '{{3'h0, in_status_in, pv[k % 16]}, 32'h1fff_ffff, 2'h0},
                {3'h0, osd_out.status, param_values_out[k % 16]}, 2'h0);
            chk_lamps();
        end
        wrap_up();
    end
endmodule
